// >>> ptl_pkg.sv
// Purpose: shared constants for the period timer with hardware limit
// Assumes: 8-bit register port, one clock domain
// Notes: register indices are word indices on the plain register port
// ============================================================
// package
package ptl_pkg;
  // ============================================================
  // register indices
  localparam logic [3:0] PTL_IDX_COUNT = 4'h0;
  localparam logic [3:0] PTL_IDX_PERIOD = 4'h1;
  localparam logic [3:0] PTL_IDX_CONTROL = 4'h2;
  localparam logic [3:0] PTL_IDX_POSTSCALE = 4'h3;
  localparam logic [3:0] PTL_IDX_LIMIT_MODE = 4'h4;
  localparam logic [3:0] PTL_IDX_SRC_SEL = 4'h5;
  localparam logic [3:0] PTL_IDX_PW_COMPARE = 4'h6;
  localparam logic [3:0] PTL_IDX_STATUS = 4'h7;
  // ============================================================
  // field positions
  localparam int PTL_CTL_RUN_BIT = 7;
  localparam int PTL_CTL_PRE_LSB = 4;
  localparam int PTL_STAT_PWM_BIT = 0;
  localparam int PTL_STAT_HALT_BIT = 1;
  localparam int PTL_STAT_RUN_BIT = 2;
  localparam int PTL_STAT_EXT_BIT = 3;
  // ============================================================
  // reset values
  localparam logic [7:0] PTL_COUNT_RST = 8'h00;
  localparam logic [7:0] PTL_PERIOD_RST = 8'hff;
  localparam logic [7:0] PTL_CONTROL_RST = 8'h00;
  localparam logic [4:0] PTL_FIELD5_RST = 5'h00;
  localparam logic [7:0] PTL_PWC_RST = 8'h00;
  // ============================================================
  // mode field: bits 4:3 pick the major mode, bits 2:0 the external function
  localparam logic [1:0] PTL_MAJ_FREE = 2'h0;
  localparam logic [1:0] PTL_MAJ_ONESHOT = 2'h1;
  localparam logic [1:0] PTL_MAJ_MONO = 2'h2;
  localparam logic [2:0] PTL_SUB_SOFT = 3'h0;
  localparam logic [2:0] PTL_SUB_GATE_HI = 3'h1;
  localparam logic [2:0] PTL_SUB_GATE_LO = 3'h2;
  localparam logic [2:0] PTL_SUB_EDGE_ANY = 3'h3;
  localparam logic [2:0] PTL_SUB_EDGE_RISE = 3'h4;
  localparam logic [2:0] PTL_SUB_EDGE_FALL = 3'h5;
  localparam logic [2:0] PTL_SUB_LVL_LO = 3'h6;
  localparam logic [2:0] PTL_SUB_LVL_HI = 3'h7;
  // ============================================================
  // timing: synchroniser depth gives two clocks of the three-clock reset latency
  localparam int PTL_SYNC_STAGES = 2;
  localparam int PTL_PRE_WIDTH = 7;
  // ============================================================
  // run state, one-hot
  typedef enum logic [2:0] {
    PTL_ST_STOP = 3'b001,
    PTL_ST_RUN = 3'b010,
    PTL_ST_HALT = 3'b100
  } ptl_state_t;
endpackage

// >>> ptl_sync.sv
// Purpose: two-flop level synchroniser for the external reset/gate source
// Assumes: input may be asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// synchroniser
module ptl_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  logic sync_reg;

  // two stages; metastability settles in the first
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule
`default_nettype wire

// >>> ptl_prescaler.sv
// Purpose: programmable power-of-two prescaler producing the tick clock
// Assumes: ratio selects divide by 1, 2, 4 up to 128
// Notes: counter holds while disabled so a gated timer resumes in phase
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// prescaler
module ptl_prescaler #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic en,
  input wire logic clr,
  input wire logic [2:0] ratio,
  // outputs
  output logic tick,
  output logic [WIDTH-1:0] cnt
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] lim;

  // terminal count for the chosen division
  assign lim = WIDTH'((1 << ratio) - 1);
  assign tick = en & (cnt_reg == lim);
  assign cnt = cnt_reg;

  // clear has priority so every clearing event restarts the division
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else if (en) begin
      cnt_reg <= cnt_reg + WIDTH'(1);
    end
  end
endmodule
`default_nettype wire

// >>> ptl_timer.sv
// Purpose: 8-bit period timer with postscaler, one-shot, monostable and hardware limit
// Assumes: register port strobes are one cycle, read data valid the next cycle
// Notes: external source is synchronised, so level effects land three clocks late
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// timer
module ptl_timer
  import ptl_pkg::*;
#(
  parameter int NUM_SRC = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // external sources and debug
  input wire logic [NUM_SRC-1:0] ext_sources,
  input wire logic debug_freeze,
  // outputs
  output logic period_pulse_out,
  output logic pwm_out,
  output logic [7:0] timer_count
);
  import ptl_pkg::*;

  // ============================================================
  // registers
  logic [7:0] count_reg, count_next;
  logic [7:0] period_value_reg;
  logic [7:0] timer_control_reg;
  logic [4:0] postscale_control_reg;
  logic [4:0] limit_mode_register_reg;
  logic [4:0] reset_source_select_reg;
  logic [7:0] pulse_width_compare_reg;
  logic [4:0] post_cnt_reg, post_cnt_next;
  logic pulse_reg, pulse_next;
  logic pwm_reg, pwm_next;
  logic prev_reg;
  logic [7:0] rdata_reg, rdata_next;
  ptl_state_t state_reg, state_next;

  // ============================================================
  // write decode
  wire wr_count = reg_wr && (reg_addr == PTL_IDX_COUNT);
  wire wr_period = reg_wr && (reg_addr == PTL_IDX_PERIOD);
  wire wr_ctrl = reg_wr && (reg_addr == PTL_IDX_CONTROL);
  wire wr_post = reg_wr && (reg_addr == PTL_IDX_POSTSCALE);
  wire wr_mode = reg_wr && (reg_addr == PTL_IDX_LIMIT_MODE);
  wire wr_sel = reg_wr && (reg_addr == PTL_IDX_SRC_SEL);
  wire wr_pwc = reg_wr && (reg_addr == PTL_IDX_PW_COMPARE);

  // ============================================================
  // mode decode
  wire [1:0] major = limit_mode_register_reg[4:3];
  wire [2:0] sub = limit_mode_register_reg[2:0];
  wire run_enable = timer_control_reg[PTL_CTL_RUN_BIT];
  wire [2:0] pre_ratio = timer_control_reg[PTL_CTL_PRE_LSB +: 3];
  wire is_oneshot = (major == PTL_MAJ_ONESHOT);
  wire is_mono = (major == PTL_MAJ_MONO);
  wire is_gate_mode = (sub == PTL_SUB_GATE_HI) || (sub == PTL_SUB_GATE_LO);

  // ============================================================
  // external source select and synchronise
  wire ext_raw = ext_sources[reset_source_select_reg];
  logic ext_s;

  ptl_sync u_sync (
    .clk(clk),
    .rst(rst),
    .din(ext_raw),
    .dout(ext_s)
  );

  // ============================================================
  // external event detection, all gated off by freeze and run enable
  wire ext_ok = run_enable && !debug_freeze;
  wire rise = ext_s && !prev_reg;
  wire fall = !ext_s && prev_reg;
  wire edge_evt = ext_ok && (((sub == PTL_SUB_EDGE_ANY) && (rise || fall)) ||
                             ((sub == PTL_SUB_EDGE_RISE) && rise) ||
                             ((sub == PTL_SUB_EDGE_FALL) && fall));
  wire level_hold = ext_ok && (((sub == PTL_SUB_LVL_LO) && !ext_s) ||
                               ((sub == PTL_SUB_LVL_HI) && ext_s));
  // a frozen gate counts as open so debug does not stall the count
  wire gate_open = !is_gate_mode || !ext_ok ||
                   ((sub == PTL_SUB_GATE_HI) && ext_s) ||
                   ((sub == PTL_SUB_GATE_LO) && !ext_s);
  wire ext_clear = edge_evt || level_hold;

  // ============================================================
  // counting qualifier and prescaler
  wire counting = (state_reg == PTL_ST_RUN) && gate_open && !level_hold;
  wire pre_clr = wr_count || wr_ctrl || ext_clear;
  logic tick;
  logic [PTL_PRE_WIDTH-1:0] pre_cnt;

  ptl_prescaler #(
    .WIDTH(PTL_PRE_WIDTH)
  ) u_pre (
    .clk(clk),
    .rst(rst),
    .en(counting),
    .clr(pre_clr),
    .ratio(pre_ratio),
    .tick(tick),
    .cnt(pre_cnt)
  );

  wire match = (count_reg == period_value_reg);
  wire match_tick = tick && match && !ext_clear;
  wire post_hit = (post_cnt_reg == postscale_control_reg);
  // monostable restart on external reset event after halting
  wire mono_restart = (state_reg == PTL_ST_HALT) && is_mono && edge_evt;
  wire oneshot_stop = match_tick && is_oneshot && (state_reg == PTL_ST_RUN);

  // ============================================================
  // run state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PTL_ST_STOP: begin
        if (run_enable) begin
          state_next = PTL_ST_RUN;
        end
      end
      PTL_ST_RUN: begin
        if (!run_enable || oneshot_stop) begin
          state_next = PTL_ST_STOP;
        end else if (match_tick && is_mono) begin
          state_next = PTL_ST_HALT;
        end
      end
      PTL_ST_HALT: begin
        if (!run_enable) begin
          state_next = PTL_ST_STOP;
        end else if (mono_restart) begin
          state_next = PTL_ST_RUN;
        end
      end
      default: begin
        state_next = PTL_ST_STOP;
      end
    endcase
  end

  // ============================================================
  // count next value; a software write beats every hardware update
  always_comb begin
    count_next = count_reg; // control writes never reach the count
    if (wr_count) begin
      count_next = reg_wdata;
    end else if (ext_clear) begin
      count_next = PTL_COUNT_RST;
    end else if (tick) begin
      count_next = match ? PTL_COUNT_RST : count_reg + 8'h01;
    end
  end

  // ============================================================
  // postscaler and period pulse
  always_comb begin
    post_cnt_next = post_cnt_reg;
    pulse_next = pulse_reg;
    if (tick) begin
      pulse_next = 1'b0; // pulse lasts exactly one tick
    end
    if (pre_clr || mono_restart || (state_reg == PTL_ST_STOP)) begin
      post_cnt_next = PTL_FIELD5_RST;
    end else if (match_tick) begin
      if (post_hit) begin
        post_cnt_next = PTL_FIELD5_RST;
        pulse_next = 1'b1;
      end else begin
        post_cnt_next = post_cnt_reg + 5'h01;
      end
    end
  end

  // ============================================================
  // pwm: clear on width match wins so a zero width gives no pulse;
  // holding through reset keeps a high output high until it counts out
  wire pwm_set = tick && counting && (count_reg == PTL_COUNT_RST);
  wire pwm_clr = tick && counting && (count_reg == pulse_width_compare_reg);
  always_comb begin
    pwm_next = pwm_reg;
    if (pwm_clr) begin
      pwm_next = 1'b0;
    end else if (pwm_set) begin
      pwm_next = 1'b1;
    end
  end

  // ============================================================
  // read mux; unmapped indices read zero
  wire [7:0] status_word = {4'h0, ext_s, (state_reg == PTL_ST_RUN),
                            (state_reg == PTL_ST_HALT), pwm_reg};
  always_comb begin
    rdata_next = 8'h00;
    if (!reg_rd) begin
      rdata_next = 8'h00;
    end else if (reg_addr == PTL_IDX_COUNT) begin
      rdata_next = count_reg;
    end else if (reg_addr == PTL_IDX_PERIOD) begin
      rdata_next = period_value_reg;
    end else if (reg_addr == PTL_IDX_CONTROL) begin
      rdata_next = timer_control_reg;
    end else if (reg_addr == PTL_IDX_POSTSCALE) begin
      rdata_next = {3'h0, postscale_control_reg};
    end else if (reg_addr == PTL_IDX_LIMIT_MODE) begin
      rdata_next = {3'h0, limit_mode_register_reg};
    end else if (reg_addr == PTL_IDX_SRC_SEL) begin
      rdata_next = {3'h0, reset_source_select_reg};
    end else if (reg_addr == PTL_IDX_PW_COMPARE) begin
      rdata_next = pulse_width_compare_reg;
    end else if (reg_addr == PTL_IDX_STATUS) begin
      rdata_next = status_word;
    end
  end

  // ============================================================
  // software registers; software write to control beats the one-shot clear
  always_ff @(posedge clk) begin
    if (rst) begin
      period_value_reg <= PTL_PERIOD_RST;
      timer_control_reg <= PTL_CONTROL_RST;
      postscale_control_reg <= PTL_FIELD5_RST;
      limit_mode_register_reg <= PTL_FIELD5_RST;
      reset_source_select_reg <= PTL_FIELD5_RST;
      pulse_width_compare_reg <= PTL_PWC_RST;
    end else begin
      if (wr_period) period_value_reg <= reg_wdata;
      if (wr_ctrl) begin
        timer_control_reg <= reg_wdata;
      end else if (oneshot_stop) begin
        timer_control_reg[PTL_CTL_RUN_BIT] <= 1'b0;
      end
      if (wr_post) postscale_control_reg <= reg_wdata[4:0];
      if (wr_mode) limit_mode_register_reg <= reg_wdata[4:0];
      if (wr_sel) reset_source_select_reg <= reg_wdata[4:0];
      if (wr_pwc) pulse_width_compare_reg <= reg_wdata;
    end
  end

  // ============================================================
  // hardware state
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= PTL_COUNT_RST;
      post_cnt_reg <= PTL_FIELD5_RST;
      pulse_reg <= 1'b0;
      pwm_reg <= 1'b0;
      prev_reg <= 1'b0;
      rdata_reg <= 8'h00;
      state_reg <= PTL_ST_STOP;
    end else begin
      count_reg <= count_next;
      post_cnt_reg <= post_cnt_next;
      pulse_reg <= pulse_next;
      pwm_reg <= pwm_next;
      prev_reg <= ext_s;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign period_pulse_out = pulse_reg;
  assign pwm_out = pwm_reg;
  assign timer_count = count_reg;

  // ============================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_plain_tick;
    tick && !match && !ext_clear && !wr_count;
  endsequence
  sequence s_match_tick;
    tick && match && !ext_clear && !wr_count;
  endsequence

  property p_count_step;
    s_plain_tick |=> (count_reg == $past(count_reg) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");
  property p_match_wrap;
    s_match_tick |=> (count_reg == 8'h00);
  endproperty
  a_match_wrap: assert property (p_match_wrap) else $error("count did not wrap");
  property p_gate_hold;
    (is_gate_mode && ext_ok && !gate_open && !wr_count && !ext_clear)
      |=> $stable(count_reg);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate shut");
  property p_level_hold;
    (level_hold && !wr_count) [*2] |-> ##1 (count_reg == 8'h00);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("count not held in reset");
  property p_ctrl_keeps_count;
    (wr_ctrl && !tick && !ext_clear) |=> $stable(count_reg) && (pre_cnt == 0);
  endproperty
  a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) else $error("control write hit count");
  property p_write_clears_post;
    (wr_count || ext_clear) |=> (post_cnt_reg == 5'h00) && (pre_cnt == 0);
  endproperty
  a_write_clears_post: assert property (p_write_clears_post) else $error("scalers not cleared");
  property p_oneshot_stop;
    (s_match_tick and (is_oneshot && state_reg == PTL_ST_RUN && !wr_ctrl))
      |=> !run_enable ##1 (state_reg == PTL_ST_STOP);
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");
  property p_mono_halt;
    (s_match_tick and (is_mono && state_reg == PTL_ST_RUN && !wr_ctrl && run_enable))
      |=> run_enable && (state_reg == PTL_ST_HALT);
  endproperty
  a_mono_halt: assert property (p_mono_halt) else $error("monostable did not halt");
  property p_freeze_ignores;
    debug_freeze |-> !ext_clear && !mono_restart;
  endproperty
  a_freeze_ignores: assert property (p_freeze_ignores) else $error("trigger seen in freeze");
  property p_pwm_holds;
    (pwm_reg && level_hold) |=> pwm_reg;
  endproperty
  a_pwm_holds: assert property (p_pwm_holds) else $error("pwm fell during reset");
  // the pulse may only drop on a tick, so it spans one whole tick period
  property p_pulse_width;
    (pulse_reg && !tick) |=> pulse_reg;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("period pulse ended early");
  property p_run_off_ignores;
    !run_enable |-> !ext_clear;
  endproperty
  a_run_off_ignores: assert property (p_run_off_ignores) else $error("input used while off");
endmodule
`default_nettype wire

// >>> ptl_ext_model.sv
// Purpose: far-side model of the external reset/gate source line
// Assumes: want is the level the bench asks for
// Notes: a requested change may lag, so the line never breaks spacing
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// external source model
module ptl_ext_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request and line
  input wire logic want,
  output logic src_line
);
  logic [3:0] gap_reg;
  // a gap count of six between changes keeps every level at least seven clocks long
  always_ff @(posedge clk) begin
    if (rst) begin
      src_line <= 1'b0;
      gap_reg <= 4'h0;
    end else if (want != src_line && gap_reg >= 4'h6) begin
      src_line <= want;
      gap_reg <= 4'h0;
    end else if (gap_reg != 4'hf) begin
      gap_reg <= gap_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> test_period_timer_with_hardware_limit.sv
// Purpose: self-checking bench for the period timer
// Assumes: source select stays 0, so bit 0 carries the model's line
// Notes: one task per scenario; level effects land three clocks late
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench
module test_period_timer_with_hardware_limit;
  import ptl_pkg::*;
  logic clk, rst, reg_wr, reg_rd, debug_freeze, want, ext_line, period_pulse_out, pwm_out;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, timer_count, d;
  logic [31:0] ext_sources;
  int mismatches, num_checks, pulse_hits;
  assign ext_sources = {31'h0, ext_line};
  ptl_timer #(.NUM_SRC(32)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_sources(ext_sources), .debug_freeze(debug_freeze),
    .period_pulse_out(period_pulse_out), .pwm_out(pwm_out), .timer_count(timer_count));
  ptl_ext_model i_ext (.clk(clk), .rst(rst), .want(want), .src_line(ext_line));
  // ============================================================
  // helpers
  always @(posedge clk) if (period_pulse_out === 1'b1) pulse_hits++;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic hold(input string what, input int n);
    logic [7:0] v;
    v = timer_count;
    tick(n);
    chk(what, v, timer_count);
  endtask
  task automatic waitc(input logic [7:0] v, input int n);
    for (int i = 0; i < n && timer_count !== v; i++) tick(1);
    chk("count reached", v, timer_count);
  endtask
  task automatic setup(input logic [7:0] mode, input logic [7:0] per);
    wr(PTL_IDX_CONTROL, 8'h00);
    wr(PTL_IDX_LIMIT_MODE, mode);
    wr(PTL_IDX_PERIOD, per);
    wr(PTL_IDX_COUNT, 8'h00);
    pulse_hits = 0;
  endtask
  task automatic edge_to(input logic v);
    @(posedge clk) want <= v;
    for (int i = 0; i < 10 && ext_line !== v; i++) tick(1);
  endtask
  // ============================================================
  // scenarios
  task automatic t_regs();
    rd(PTL_IDX_COUNT, d);
    chk("count at reset", 8'h00, d);
    rd(PTL_IDX_PERIOD, d);
    chk("period at reset", 8'hff, d);
    wr(PTL_IDX_PERIOD, 8'h3c);
    wr(PTL_IDX_COUNT, 8'h5a);
    rd(PTL_IDX_PERIOD, d);
    chk("period", 8'h3c, d);
    rd(PTL_IDX_COUNT, d);
    chk("count", 8'h5a, d);
    rd(4'hc, d);
    chk("unmapped", 8'h00, d);
    $display("test regs done");
  endtask
  // divide by 128: without the prescaler clear a tick would land in the hold
  task automatic t_presc();
    wr(PTL_IDX_CONTROL, 8'hf0);
    wr(PTL_IDX_COUNT, 8'h10);
    tick(100);
    wr(PTL_IDX_CONTROL, 8'hf0);
    hold("count across control write", 100);
    waitc(8'h11, 40);
    $display("test prescaler done");
  endtask
  task automatic t_free();
    int wraps;
    logic [7:0] last;
    wraps = 0;
    setup(8'h00, 8'h03);
    wr(PTL_IDX_POSTSCALE, 8'h01);
    wr(PTL_IDX_CONTROL, 8'h80);
    tick(8);
    pulse_hits = 0;
    for (int i = 0; i < 80; i++) begin
      last = timer_count;
      tick(1);
      if (last === 8'h03 && timer_count === 8'h00) wraps++;
    end
    chk("wraps in 80 clocks", 8'd20, 8'(wraps));
    chk("pulse clocks", 8'd10, 8'(pulse_hits));
    $display("test free-run done");
  endtask
  task automatic t_oneshot();
    setup(8'h08, 8'h03);
    wr(PTL_IDX_CONTROL, 8'h80);
    tick(20);
    rd(PTL_IDX_CONTROL, d);
    chk("run bit", 8'h00, d & 8'h80);
    hold("stopped count", 10);
    wr(PTL_IDX_COUNT, 8'h00);
    wr(PTL_IDX_CONTROL, 8'h80);
    waitc(8'h02, 8);
    tick(10);
    chk("pulses", 8'h00, 8'(pulse_hits));
    $display("test one-shot done");
  endtask
  task automatic t_mono();
    setup(8'h14, 8'h03);
    wr(PTL_IDX_CONTROL, 8'h80);
    tick(20);
    rd(PTL_IDX_CONTROL, d);
    chk("run bit", 8'h80, d & 8'h80);
    hold("halted count", 10);
    edge_to(1'b1);
    waitc(8'h02, 10);
    $display("test monostable done");
  endtask
  task automatic t_gate();
    setup(8'h01, 8'hff);
    wr(PTL_IDX_CONTROL, 8'h80);
    tick(10);
    edge_to(1'b0);
    tick(4);
    hold("gated count", 10);
    d = timer_count;
    edge_to(1'b1);
    tick(8);
    chk("resumed", 8'h01, {7'h0, timer_count > d && timer_count < d + 8'd12});
    $display("test gate done");
  endtask
  task automatic t_limit();
    edge_to(1'b0);
    setup(8'h07, 8'hff);
    wr(PTL_IDX_PW_COMPARE, 8'h40);
    wr(PTL_IDX_CONTROL, 8'h80);
    waitc(8'h10, 30);
    chk("pwm while counting", 8'h01, {7'h0, pwm_out});
    edge_to(1'b1);
    d = timer_count;
    tick(2);
    chk("count two clocks on", d + 8'h02, timer_count);
    tick(1);
    chk("count in limit", 8'h00, timer_count);
    hold("held in limit", 10);
    chk("pwm in reset", 8'h01, {7'h0, pwm_out});
    edge_to(1'b0);
    waitc(8'h03, 10);
    waitc(8'h45, 80);
    chk("pwm past compare", 8'h00, {7'h0, pwm_out});
    wr(PTL_IDX_LIMIT_MODE, 8'h06);
    tick(5);
    chk("held while low", 8'h00, timer_count);
    wr(PTL_IDX_CONTROL, 8'h00);
    wr(PTL_IDX_LIMIT_MODE, 8'h07);
    wr(PTL_IDX_COUNT, 8'h20);
    edge_to(1'b1);
    tick(8);
    chk("input ignored when off", 8'h20, timer_count);
    @(posedge clk) debug_freeze <= 1'b1;
    wr(PTL_IDX_CONTROL, 8'h80);
    tick(8);
    chk("frozen", 8'h01, {7'h0, timer_count > 8'h20});
    @(posedge clk) debug_freeze <= 1'b0;
    tick(5);
    chk("limit after freeze", 8'h00, timer_count);
    $display("test limit done");
  endtask
  // gate-low from a held count, then falling-edge and any-edge resets, each against a running count
  task automatic t_resets();
    setup(8'h02, 8'hff);
    wr(PTL_IDX_CONTROL, 8'h80);
    tick(10);
    chk("count with low gate shut", 8'h00, timer_count);
    edge_to(1'b0);
    tick(8);
    chk("low gate open", 8'h01, {7'h0, timer_count != 8'h00});
    wr(PTL_IDX_LIMIT_MODE, 8'h05);
    edge_to(1'b1);
    tick(4);
    chk("rise ignored in fall mode", 8'h01, {7'h0, timer_count > 8'h08});
    edge_to(1'b0);
    tick(3);
    chk("count at falling reset", 8'h00, timer_count);
    wr(PTL_IDX_LIMIT_MODE, 8'h03);
    edge_to(1'b1);
    tick(3);
    chk("count at any-edge reset", 8'h00, timer_count);
    $display("test reset modes done");
  endtask
  // ============================================================
  // verdict
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // the tests take under 1000 clocks; the watchdog allows over twenty times that
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    debug_freeze = 1'b0;
    want = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_presc();
    t_free();
    t_oneshot();
    t_mono();
    t_gate();
    t_limit();
    t_resets();
    end_of_test();
  end
endmodule
`default_nettype wire
